// ### design/cache_ctrl.sv
// Sequencer of a direct-mapped write-through cache with posted writes.
// Assumes the processor bus, the system bus and the local device all run
// on clk, and that both tag stores and the data store are external SRAMs.
//
// How it works
// - Read start keeps tag stores in compare
// - Second state hit drives data store out
// - Read miss opens processor to system buffer
// - Read miss copies strobe and direction outward
// - Read miss fills data and both tags
// - Processor ready follows system ready on read miss
// - Write start keeps tag stores in compare
// - Write hit writes processor data to store
// - Every cacheable write pulses the posted latch enable
// - Writes begin before the hit is known
// - Write miss invalidates index in both tags
// - Local device cycles leave cache untouched
// - Local ready ends a local device cycle
// - Uncached cycles leave cache state unchanged
// - Index bits 2-14, tag bits 15-31
// - Invalidation stores low valid bit 23
// - Uncached cycles float tag store outputs
// - Bus watch hit clears both tag stores
// - Data store indexed by bits 2-14, four lanes
// - Read miss fills the whole word
// - Force enable gates all byte selects on
// - Reset leaves tag stores cleared
// - Foreign system writes compared by bus watch
// - Posted write finishes before hold grant
// - Write hit fast, write miss one extra
`timescale 1ns/1ps
`default_nettype none

module cache_ctrl
  import cache_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Processor bus.
  input wire logic addr_strobe_n,
  input wire logic write_not_read,
  input wire logic [`CC_TAG_MSB:`CC_INDEX_LSB] cpu_addr,
  input wire logic [`CC_LANES-1:0] cpu_byte_en_n,
  input wire logic local_device_access_n,
  input wire logic noncacheable_n,
  input wire logic local_ready_n,
  output logic cpu_ready_n,
  // Processor tag store and bus-watch tag store.
  input wire logic tag_match,
  input wire logic bus_watch_match,
  output logic tag_chip_en_n,
  output logic tag_write_en_n,
  output logic tag_invalidate_n,
  output logic tag_clear_n,
  output logic [`CC_INDEX_W-1:0] tag_index,
  output tag_entry_t tag_wr_data,
  // Data store.
  output logic [`CC_INDEX_W-1:0] cache_index,
  output logic cache_out_en_n,
  output logic cache_write_en_n,
  output logic force_byte_en_n,
  output logic [`CC_LANES-1:0] cache_byte_sel_n,
  // Data buffers and posted-write latches.
  output logic buffer_en_n,
  output logic buffer_dir,
  output logic post_latch_en,
  // System bus.
  input wire logic sys_ready_n,
  input wire logic sys_hold_req,
  input wire logic ext_addr_strobe_n,
  input wire logic ext_write,
  output logic sys_addr_strobe_n,
  output logic sys_write_not_read,
  output logic sys_hold_ack
);

  // ---------------------------------------------------------------------
  // State and decode
  // ---------------------------------------------------------------------

  cyc_state_t state_reg;
  cyc_state_t state_next;
  cpu_cycle_t cyc_reg;
  logic sys_active_reg;
  logic post_busy_reg;
  logic sys_strobe_reg;
  logic sys_wnr_reg;
  logic hold_ack_reg;
  logic watch_clr_reg;
  logic bus_free;
  logic bypass;
  logic in_second;
  logic second_read;
  logic second_write_go;
  logic sys_start;
  logic sys_done;

  // A cycle for a local device or an uncached address bypasses the cache.
  assign bypass = cyc_reg.local_acc | cyc_reg.uncached;
  assign in_second = (state_reg == SECOND_BUS_STATE);
  assign second_read = in_second & ~bypass & ~cyc_reg.wnr;

  // The system bus may be started only when nothing holds or wants it.
  assign bus_free = ~sys_active_reg & ~hold_ack_reg & ~sys_hold_req;

  // A cacheable write proceeds once the posted buffer can take it.
  assign second_write_go = in_second & ~bypass & cyc_reg.wnr & bus_free;
  assign sys_done = sys_active_reg & ~sys_ready_n;

  // Starts of system cycles: posted write, read miss fill, uncached cycle.
  always_comb begin
    sys_start = 1'b0;
    if (second_write_go) begin
      sys_start = 1'b1;
    end else if (in_second & bus_free & cyc_reg.uncached
                 & ~cyc_reg.local_acc) begin
      sys_start = 1'b1;
    end else if (second_read & ~tag_match & bus_free) begin
      sys_start = 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Processor cycle capture
  // ---------------------------------------------------------------------

  // The cycle is captured at the strobe so index and tag come from flops.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cyc_reg <= '0;
    end else if (state_reg == IDLE && !addr_strobe_n) begin
      cyc_reg.wnr <= write_not_read;
      cyc_reg.local_acc <= ~local_device_access_n;
      cyc_reg.uncached <= ~noncacheable_n;
      cyc_reg.be_n <= cpu_byte_en_n;
      cyc_reg.addr <= cpu_addr;
    end
  end

  // Index and entry for both tag stores and the data store.
  assign tag_index = cyc_reg.addr[`CC_INDEX_MSB:`CC_INDEX_LSB];
  assign cache_index = cyc_reg.addr[`CC_INDEX_MSB:`CC_INDEX_LSB];
  assign tag_wr_data.tag = cyc_reg.addr[`CC_TAG_MSB:`CC_TAG_LSB];
  assign tag_wr_data.spare = '0;
  // Fills write a set valid bit; write misses write it clear.
  assign tag_wr_data.valid = ~cyc_reg.wnr;

  // ---------------------------------------------------------------------
  // Processor bus sequence
  // ---------------------------------------------------------------------

  // Next state of the processor cycle.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      IDLE: begin
        if (!addr_strobe_n) begin
          state_next = SECOND_BUS_STATE;
        end
      end
      SECOND_BUS_STATE: begin
        if (cyc_reg.local_acc) begin
          state_next = LOCAL_CYCLE;
        end else if (cyc_reg.uncached) begin
          if (bus_free) begin
            state_next = UNCACHED_CYCLE;
          end
        end else if (!cyc_reg.wnr) begin
          if (tag_match) begin
            state_next = IDLE;
          end else if (bus_free) begin
            state_next = READ_MISS;
          end
        end else if (bus_free) begin
          state_next = tag_match ? IDLE : WRITE_MISS;
        end
      end
      READ_MISS: begin
        if (sys_done) begin
          state_next = IDLE;
        end
      end
      WRITE_MISS: begin
        state_next = IDLE;
      end
      LOCAL_CYCLE: begin
        if (!local_ready_n) begin
          state_next = IDLE;
        end
      end
      UNCACHED_CYCLE: begin
        if (sys_done) begin
          state_next = IDLE;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------
  // System bus engine
  // ---------------------------------------------------------------------

  // One system cycle at a time; the strobe is low for its first cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_active_reg <= 1'b0;
      sys_strobe_reg <= 1'b0;
      sys_wnr_reg <= 1'b0;
    end else begin
      sys_strobe_reg <= sys_start;
      if (sys_start) begin
        sys_active_reg <= 1'b1;
        sys_wnr_reg <= cyc_reg.wnr;
      end else if (sys_done) begin
        sys_active_reg <= 1'b0;
      end
    end
  end

  // The posted write stays locked on the bus until memory answers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      post_busy_reg <= 1'b0;
    end else if (second_write_go) begin
      post_busy_reg <= 1'b1;
    end else if (sys_done) begin
      post_busy_reg <= 1'b0;
    end
  end

  // Hold is granted only between system cycles and dropped with request.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_ack_reg <= 1'b0;
    end else if (!sys_hold_req) begin
      hold_ack_reg <= 1'b0;
    end else if (!sys_active_reg && !sys_start) begin
      hold_ack_reg <= 1'b1;
    end
  end

  // A foreign write that hits the bus-watch tag flushes both stores.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      watch_clr_reg <= 1'b0;
    end else begin
      watch_clr_reg <= hold_ack_reg & ~ext_addr_strobe_n & ext_write
                       & bus_watch_match;
    end
  end

  assign sys_addr_strobe_n = ~sys_strobe_reg;
  assign sys_write_not_read = sys_wnr_reg;
  assign sys_hold_ack = hold_ack_reg;

  // ---------------------------------------------------------------------
  // Store and buffer controls
  // ---------------------------------------------------------------------

  // Tag stores compare by default; they write only on a read miss fill.
  assign tag_write_en_n = ~(state_reg == READ_MISS);
  // Bypassed cycles disable the tag stores so nothing is entered.
  assign tag_chip_en_n = (state_reg != IDLE) & bypass;
  assign tag_invalidate_n = ~(second_write_go & ~tag_match);
  // Cleared while reset is applied and on a bus-watch hit.
  assign tag_clear_n = ~(sys_rst | watch_clr_reg);

  assign cache_out_en_n = ~(second_read & tag_match);
  // Writes enter the store speculatively; a miss is repaired by invalidate.
  assign cache_write_en_n = ~(second_write_go | state_reg == READ_MISS);
  assign force_byte_en_n = ~(state_reg == READ_MISS);
  assign post_latch_en = second_write_go;

  // Each lane select is its processor enable, forced on by a fill.
  genvar lane;
  generate
    for (lane = 0; lane < `CC_LANES; lane = lane + 1) begin : g_lane
      assign cache_byte_sel_n[lane] = cyc_reg.be_n[lane] & force_byte_en_n;
    end
  endgenerate

  // The processor data bus meets the system bus for fills and transfers.
  assign buffer_en_n = ~(state_reg == READ_MISS | state_reg == UNCACHED_CYCLE
                         | post_busy_reg);
  assign buffer_dir = post_busy_reg
                      | (state_reg == UNCACHED_CYCLE & cyc_reg.wnr);

  // Processor ready: hits at once, write miss a cycle later, else on answer.
  assign cpu_ready_n = ~((second_read & tag_match)
                         | (second_write_go & tag_match)
                         | (state_reg == WRITE_MISS)
                         | (state_reg == READ_MISS & sys_done)
                         | (state_reg == UNCACHED_CYCLE & sys_done)
                         | (state_reg == LOCAL_CYCLE & ~local_ready_n));

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_read_probe_compare:
  assert property ((state_reg == IDLE && !addr_strobe_n && !write_not_read)
                   |=> tag_write_en_n && in_second)
    else $error("Read start did not hold tag stores in compare.");

  a_hit_data_out:
  assert property (second_read && tag_match |-> !cache_out_en_n && !cpu_ready_n
                   ##1 state_reg == IDLE)
    else $error("Read hit did not drive the data store.");

  a_miss_opens_buffer:
  assert property (second_read && !tag_match && bus_free
                   |=> !buffer_en_n && state_reg == READ_MISS)
    else $error("Read miss did not join the data buses.");

  a_miss_sys_strobe:
  assert property (state_reg == READ_MISS && $past(state_reg) != READ_MISS
                   |-> !sys_addr_strobe_n && !sys_write_not_read)
    else $error("Read miss did not start a system read.");

  a_fill_all_stores:
  assert property (state_reg == READ_MISS |-> !tag_write_en_n
                   && !cache_write_en_n && cache_byte_sel_n == 4'h0)
    else $error("Read miss fill missing a store enable.");

  a_ready_after_sys:
  assert property (state_reg == READ_MISS && !cpu_ready_n |-> !sys_ready_n)
    else $error("Processor released before system ready.");

  a_write_compare:
  assert property ((state_reg == IDLE && !addr_strobe_n && write_not_read)
                   |=> tag_write_en_n)
    else $error("Write start did not keep tags in compare.");

  a_post_and_write:
  assert property (post_latch_en |-> !cache_write_en_n ##1
                   (!sys_addr_strobe_n && sys_write_not_read && post_busy_reg))
    else $error("Posted write not latched and started.");

  a_write_miss_inval:
  assert property (post_latch_en && !tag_match |-> !tag_invalidate_n
                   && cpu_ready_n ##1 !cpu_ready_n)
    else $error("Write miss not invalidated or not one cycle longer.");

  a_write_hit_fast:
  assert property (post_latch_en && tag_match |-> !cpu_ready_n
                   && tag_invalidate_n)
    else $error("Write hit did not finish in the second state.");

  a_local_quiet:
  assert property (state_reg == LOCAL_CYCLE |-> tag_chip_en_n
                   && tag_write_en_n && cache_out_en_n && cache_write_en_n)
    else $error("Cache touched during a local device cycle.");

  a_local_ready_end:
  assert property (state_reg == LOCAL_CYCLE && !local_ready_n
                   |-> !cpu_ready_n ##1 state_reg == IDLE)
    else $error("Local ready did not end the cycle.");

  a_uncached_quiet:
  assert property (state_reg == UNCACHED_CYCLE |-> tag_chip_en_n
                   && tag_write_en_n && cache_out_en_n && cache_write_en_n)
    else $error("Cache touched during an uncached cycle.");

  a_force_all_lanes:
  assert property (!force_byte_en_n |-> cache_byte_sel_n == 4'h0)
    else $error("Forced fill left a byte lane off.");

  a_watch_flush:
  assert property (hold_ack_reg && !ext_addr_strobe_n && ext_write
                   && bus_watch_match |=> !tag_clear_n)
    else $error("Bus watch hit did not clear the tags.");

  a_post_locked:
  assert property (post_busy_reg |-> !sys_hold_ack)
    else $error("Hold granted during a posted write.");

  a_hold_grant_idle:
  assert property ($rose(sys_hold_ack) |-> $past(sys_hold_req)
                   && !sys_active_reg)
    else $error("Hold granted while the system bus was busy.");

endmodule // cache_ctrl

`default_nettype wire

// ### inc/cache_ctrl_pkg.sv
// Types shared by the cache sequencer and its bench.
// Assumes cache_ctrl_regs.svh is on the include path.
`include "cache_ctrl_regs.svh"

package cache_ctrl_pkg;

  // Processor bus sequence.
  typedef enum logic [2:0] {
    IDLE,
    SECOND_BUS_STATE,
    READ_MISS,
    WRITE_MISS,
    LOCAL_CYCLE,
    UNCACHED_CYCLE
  } cyc_state_t;

  // Processor cycle captured when the address strobe is seen.
  typedef struct packed {
    logic wnr;
    logic local_acc;
    logic uncached;
    logic [`CC_LANES-1:0] be_n;
    logic [`CC_TAG_MSB:`CC_INDEX_LSB] addr;
  } cpu_cycle_t;

  // Entry written into both tag stores.
  typedef struct packed {
    logic valid;
    logic [`CC_SPARE_W-1:0] spare;
    logic [`CC_TAG_W-1:0] tag;
  } tag_entry_t;

endpackage

// ### inc/cache_ctrl_regs.svh
// Constants for the direct-mapped write-through cache sequencer.
// Assumes a 32-bit processor address with the word bits starting at bit 2.
`ifndef CACHE_CTRL_REGS_SVH
`define CACHE_CTRL_REGS_SVH

// Address split between index and tag.
`define CC_INDEX_LSB 2
`define CC_INDEX_MSB 14
`define CC_TAG_LSB 15
`define CC_TAG_MSB 31
`define CC_INDEX_W 13
`define CC_TAG_W 17

// Tag entry layout: 24 bits, valid flag in the top bit.
`define CC_ENTRY_W 24
`define CC_VALID_BIT 23
`define CC_SPARE_W 6

// Data word is split into byte lanes.
`define CC_LANES 4

// Least reset length in clock periods.
`define CC_RESET_CYCLES 8

`endif

// ### test/cache_ctrl_tb.sv
// Self-checking bench of the cache sequencer.
// Assumes the package is compiled first; the bench plays processor,
// tag stores and local device, the memory model answers system cycles.
`timescale 1ns/1ps
`default_nettype none

module cache_ctrl_tb
  import cache_ctrl_pkg::*;
;
  // ----------------------------------------
  // Signals and stimulus table
  // ----------------------------------------
  localparam int WAIT = 3;
  localparam int MISS = 2 + WAIT;
  localparam logic [31:2] ADDR = 30'h2B47_9C3D;
  typedef struct packed {
    logic wnr;
    logic loc;
    logic unc;
    logic hit;
    logic [3:0] be_n;
    logic [3:0] lat;
  } row_t;
  logic clk = 1'b0, sys_rst = 1'b1, addr_strobe_n = 1'b1;
  logic write_not_read = 1'b0, local_device_access_n = 1'b1;
  logic noncacheable_n = 1'b1, local_ready_n = 1'b0, tag_match = 1'b0;
  logic bus_watch_match = 1'b0, sys_ready_n, sys_hold_req = 1'b0;
  logic ext_addr_strobe_n = 1'b1, ext_write = 1'b0;
  logic [31:2] cpu_addr = ADDR;
  logic [3:0] cpu_byte_en_n = 4'hF, cache_byte_sel_n;
  logic [7:0] wait_cycles = 8'(WAIT);
  logic cpu_ready_n, tag_chip_en_n, tag_write_en_n, tag_invalidate_n;
  logic tag_clear_n, cache_out_en_n, cache_write_en_n, force_byte_en_n;
  logic buffer_en_n, buffer_dir, post_latch_en, sys_addr_strobe_n;
  logic sys_write_not_read, sys_hold_ack;
  logic [12:0] tag_index, cache_index;
  tag_entry_t tag_wr_data;
  int error_cnt = 0, compares = 0, lat, lat2;
  // Set while a posted write still holds the system bus at a new write.
  logic posted_busy = 1'b0;
  row_t rows [9] = '{
    '{1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 4'h1},
    '{1'b0, 1'b0, 1'b0, 1'b1, 4'hE, 4'h1},
    '{1'b0, 1'b0, 1'b0, 1'b0, 4'hE, 4'(MISS)},
    '{1'b1, 1'b0, 1'b0, 1'b1, 4'h0, 4'h1},
    '{1'b1, 1'b0, 1'b0, 1'b0, 4'h3, 4'h2},
    '{1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 4'h2},
    '{1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 4'h2},
    '{1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 4'(MISS)},
    '{1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 4'(MISS)}
  };

  // Clock of 40 ns.
  always #20 clk = ~clk;

  cache_ctrl DUT (.clk, .sys_rst, .addr_strobe_n, .write_not_read,
    .cpu_addr, .cpu_byte_en_n, .local_device_access_n, .noncacheable_n,
    .local_ready_n, .cpu_ready_n, .tag_match, .bus_watch_match,
    .tag_chip_en_n, .tag_write_en_n, .tag_invalidate_n, .tag_clear_n,
    .tag_index, .tag_wr_data, .cache_index, .cache_out_en_n,
    .cache_write_en_n, .force_byte_en_n, .cache_byte_sel_n, .buffer_en_n,
    .buffer_dir, .post_latch_en, .sys_ready_n, .sys_hold_req,
    .ext_addr_strobe_n, .ext_write, .sys_addr_strobe_n,
    .sys_write_not_read, .sys_hold_ack);

  sys_mem_model mem (.clk, .sys_rst, .wait_cycles, .sys_addr_strobe_n,
    .sys_ready_n);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Counts one comparison and reports a miss at once.
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Runs one processor cycle from a clock edge and checks each cycle.
  task automatic run_cycle(input row_t r, output int n);
    logic byp;
    byp = r.loc | r.unc;
    n = 0;
    addr_strobe_n <= 1'b0;
    write_not_read <= r.wnr;
    local_device_access_n <= ~r.loc;
    noncacheable_n <= ~r.unc;
    cpu_byte_en_n <= r.be_n;
    tag_match <= r.hit;
    @(posedge clk);
    addr_strobe_n <= 1'b1;
    while (n < 40) begin
      n++;
      #1;
      if (byp) begin
        chk(cache_out_en_n & cache_write_en_n & tag_write_en_n & tag_invalidate_n, "bypass cycle touched the cache");
        if (n >= 2) chk(tag_chip_en_n === 1'b1, "tag store enabled");
      end else if (n == 1) begin
        chk(tag_write_en_n === 1'b1, "tags not in compare");
        if (!r.wnr && r.hit) chk(cache_out_en_n === 1'b0 && cache_byte_sel_n === r.be_n, "read hit output");
        if (r.wnr && !posted_busy) chk(post_latch_en === 1'b1 && cache_write_en_n === 1'b0, "write not begun");
        if (r.wnr && !posted_busy) chk(tag_invalidate_n === r.hit, "invalidate wrong");
        if (r.wnr && !r.hit) chk(tag_wr_data.valid === 1'b0, "valid not cleared");
      end else if (r.wnr && n == 2 && !posted_busy) begin
        chk(sys_addr_strobe_n === 1'b0 && sys_write_not_read === 1'b1 && buffer_dir === 1'b1, "posted write");
      end else if (!r.wnr && cpu_ready_n === 1'b1) begin
        chk({buffer_en_n, tag_write_en_n, force_byte_en_n, cache_byte_sel_n, sys_write_not_read} === 8'h00, "read miss fill");
        if (n == 2) chk(sys_addr_strobe_n === 1'b0, "no system strobe");
        chk(tag_wr_data === {1'b1, 6'h00, ADDR[31:15]}, "fill tag");
        chk(tag_index === ADDR[14:2] && cache_index === ADDR[14:2], "index");
      end
      if (r.wnr && r.hit && !byp && cpu_ready_n === 1'b0)
        chk(post_latch_en === 1'b1 && cache_write_en_n === 1'b0, "write hit end");
      if (cpu_ready_n === 1'b0) break;
      @(posedge clk);
    end
    @(posedge clk);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  // Watchdog against a hung handshake.
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end

  // Reset, table of ordinary cycles, then the awkward cases.
  initial begin
    repeat (5) @(posedge clk);
    #1;
    chk(tag_clear_n === 1'b0 && cpu_ready_n === 1'b1 && sys_hold_ack === 1'b0, "reset state");
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(tag_clear_n === 1'b1, "flush held after reset");
    @(posedge clk);
    foreach (rows[i]) begin
      run_cycle(rows[i], lat);
      chk(lat == int'(rows[i].lat), "cycle length");
      repeat (8) @(posedge clk);
    end
    // A slow local device sets the cycle length.
    local_ready_n <= 1'b1;
    @(posedge clk);
    fork
      run_cycle(rows[5], lat);
      begin
        repeat (4) @(posedge clk);
        local_ready_n <= 1'b0;
      end
    join
    chk(lat == 4, "local ready ignored");
    // A fast memory shortens the read miss.
    wait_cycles <= 8'h01;
    run_cycle(rows[2], lat);
    chk(lat == 3, "fast read miss");
    wait_cycles <= 8'(WAIT);
    repeat (4) @(posedge clk);
    // Back-to-back writes wait for the posted write.
    run_cycle(rows[4], lat);
    posted_busy = 1'b1;
    run_cycle(rows[3], lat2);
    posted_busy = 1'b0;
    chk(lat == 2 && lat2 > 1 && lat2 < 8, "back to back writes");
    repeat (8) @(posedge clk);
    // Hold request while a posted write is still running.
    run_cycle(rows[3], lat);
    sys_hold_req <= 1'b1;
    @(posedge clk);
    #1;
    chk(sys_hold_ack === 1'b0, "hold granted mid write");
    repeat (5) @(posedge clk);
    #1;
    chk(sys_hold_ack === 1'b1, "hold not granted");
    @(posedge clk);
    ext_addr_strobe_n <= 1'b0;
    ext_write <= 1'b1;
    bus_watch_match <= 1'b1;
    @(posedge clk);
    ext_addr_strobe_n <= 1'b1;
    ext_write <= 1'b0;
    bus_watch_match <= 1'b0;
    #1;
    chk(tag_clear_n === 1'b0, "watch hit no flush");
    @(posedge clk);
    #1;
    chk(tag_clear_n === 1'b1, "flush too long");
    @(posedge clk);
    sys_hold_req <= 1'b0;
    @(posedge clk);
    #1;
    chk(sys_hold_ack === 1'b0, "hold not released");
    report_and_stop;
  end
endmodule // cache_ctrl_tb

`default_nettype wire

// ### test/sys_mem_model.sv
// System memory responder that stands on the far side of the sequencer.
// Assumes the strobe and ready are both seen on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none

module sys_mem_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Access time in cycles after the strobe, 1 is the fastest answer.
  input wire logic [7:0] wait_cycles,
  // System bus.
  input wire logic sys_addr_strobe_n,
  output logic sys_ready_n
);
  logic [7:0] wait_reg;

  // Counts the access time down from each system strobe.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_reg <= 8'h00;
    end else if (!sys_addr_strobe_n) begin
      wait_reg <= wait_cycles;
    end else if (wait_reg != 8'h00) begin
      wait_reg <= wait_reg - 8'h01;
    end
  end

  // Ready is low for one cycle once the data is there, high otherwise.
  assign sys_ready_n = (wait_reg != 8'h01);
endmodule // sys_mem_model

`default_nettype wire
